/* lrs_pkg.sv */
// Constants, modes and register layout of the LUT/RAM/shift slice
//
// Overview of operation
// [RULE_01] Slice flip-flops load only on clock edges with clock enable high.
// [RULE_02] Flip-flop data comes from either bypass or either wide-mux input.
// [RULE_03] Synchronous reset, when configured, clears the flip-flop at the edge.
// [RULE_04] Registered results appear on lower or upper registered output after the edge.
// [RULE_05] Each table holds 16 one-bit locations selected by four address inputs.
// [RULE_06] Write enable high at an edge overwrites the addressed location.
// [RULE_07] A newly written bit shows on the table output after the edge.
// [RULE_08] User logic raises write enable before the intended write edge.
// [RULE_09] RAM write enable comes through the set/reset input in RAM mode.
// [RULE_10] RAM write data enters through the lower or upper bypass input; when linked the upper table writes the lower tail instead.
// [RULE_11] RAM read is combinational, always showing the addressed location.
// [RULE_12] User logic may move the address freely while write enable is low.
// [RULE_13] Address F shows its stored bit without any clock edge.
// [RULE_14] Written RAM data is also visible on the wide-mux output.
// [RULE_15] In shift mode the clock enable is the shift enable.
// [RULE_16] The bit leaving the chain drives cascade and side outputs.
// [RULE_17] Each enabled shift moves contents up and loads serial input at zero.
// [RULE_18] Shift reads are asynchronous; address changes at an edge give invalid data.
// [RULE_19] First bit shifted in reaches position 15 after sixteen enabled clocks.
// [RULE_20] After a synchronous clear the flip-flop holds zero until an enabled load.
package lrs_pkg;
	localparam int LRS_ADDR_W = 4;
	localparam int LRS_DEPTH = 16;
	localparam int LRS_CNT_W = 5;
	localparam logic [4:0] LRS_PRIMED_CNT = 5'h10;
	// Avalon byte offsets
	localparam logic [3:0] LRS_CFG_OFS = 4'h0;
	localparam logic [3:0] LRS_STAT_OFS = 4'h4;
	// Configuration fields
	localparam int LRS_CFG_W = 10;
	localparam logic [9:0] LRS_CFG_RST = 10'h000;
	localparam int LRS_CFG_LMODE = 0;
	localparam int LRS_CFG_UMODE = 1;
	localparam int LRS_CFG_LSEL = 2;
	localparam int LRS_CFG_USEL = 4;
	localparam int LRS_CFG_SRST = 6;
	localparam int LRS_CFG_LOSEL = 7;
	localparam int LRS_CFG_UOSEL = 8;
	localparam int LRS_CFG_LINK = 9;
	// Status fields
	localparam int LRS_ST_LREG = 0;
	localparam int LRS_ST_UREG = 1;
	localparam int LRS_ST_LLUT = 2;
	localparam int LRS_ST_ULUT = 3;
	localparam int LRS_ST_LTAIL = 4;
	localparam int LRS_ST_UTAIL = 5;
	localparam int LRS_ST_LPRIM = 6;
	localparam int LRS_ST_UPRIM = 7;
	// Table mode
	localparam logic LRS_MODE_RAM = 1'b0;
	localparam logic LRS_MODE_SHIFT = 1'b1;
	// Flip-flop data source codes
	localparam logic [1:0] LRS_D_BYP_LO = 2'h0;
	localparam logic [1:0] LRS_D_BYP_HI = 2'h1;
	localparam logic [1:0] LRS_D_WIDE_A = 2'h2;
	localparam logic [1:0] LRS_D_WIDE_B = 2'h3;
	typedef enum logic [1:0] {
		LRS_BUS_IDLE = 2'b01,
		LRS_BUS_ANS = 2'b10
	} lrs_bus_e;
endpackage : lrs_pkg

/* lrs_lut_table.sv */
// One 16x1 look-up table usable as RAM or as addressable shift chain
`timescale 1ns/1ps
`default_nettype none
module lrs_lut_table
	import lrs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_sync_b,
	input wire logic mode,
	input wire logic write_en,
	input wire logic shift_en,
	input wire logic write_data_in,
	input wire logic [LRS_ADDR_W-1:0] addr,
	output logic lut_out,
	output logic chain_tail_out
);
	// [RULE_05] sixteen one-bit locations
	logic [LRS_DEPTH-1:0] mem_q;
	logic [LRS_DEPTH-1:0] mem_d;

	always_comb begin
		mem_d = mem_q;
		if (mode == LRS_MODE_RAM) begin
			// [RULE_06] addressed overwrite
			if (write_en) begin
				mem_d[addr] = write_data_in;
			end
		end else begin
			// [RULE_17] shift and load position zero
			if (shift_en) begin
				mem_d = {mem_q[LRS_DEPTH-2:0], write_data_in};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mem_q <= '0;
		end else begin
			mem_q <= mem_d;
		end
	end

	// [RULE_11] combinational addressed read
	// [RULE_18] shift reads use the same path
	assign lut_out = mem_q[addr];
	// [RULE_16] bit leaving the chain
	assign chain_tail_out = mem_q[LRS_DEPTH-1];

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	a_shift_moves: assert property ( // RULE_17
		mode == LRS_MODE_SHIFT && shift_en |=> mem_q[LRS_DEPTH-1:1] == $past(mem_q[LRS_DEPTH-2:0])
	) else $error("shift chain did not move up by one");
	a_ram_others_kept: assert property ( // RULE_06
		mode == LRS_MODE_RAM && write_en && $stable(mode) |=>
			((mem_q ^ $past(mem_q)) & ~(16'h0001 << $past(addr))) == 16'h0000
	) else $error("RAM write disturbed another location");
	a_idle_keeps: assert property ( // RULE_12
		!write_en && !shift_en |=> $stable(mem_q)
	) else $error("table changed without a write or shift");
endmodule : lrs_lut_table
`default_nettype wire

/* lrs_slice.sv */
// Slice top: two tables, two flip-flops, output muxes and Avalon registers
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lrs_slice
	import lrs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic clk_en,
	input wire logic set_reset_in,
	input wire logic bypass_in_low,
	input wire logic bypass_in_high,
	input wire logic wide_mux_in_a,
	input wire logic wide_mux_in_b,
	input wire logic wide_mux_sel,
	input wire logic [LRS_ADDR_W-1:0] lower_addr,
	input wire logic [LRS_ADDR_W-1:0] upper_addr,
	output logic lower_reg_out,
	output logic upper_reg_out,
	output logic lower_lut_out,
	output logic upper_lut_out,
	output logic lower_mux_out,
	output logic upper_mux_out,
	output logic wide_mux_out,
	output logic lower_side_out,
	output logic upper_side_out,
	output logic cascade_out
);
	logic rst_s1_q;
	logic rst_sync_b;
	logic [LRS_CFG_W-1:0] cfg_q;
	logic [LRS_CFG_W-1:0] cfg_d;
	lrs_bus_e bus_q;
	lrs_bus_e bus_d;
	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic lreg_q;
	logic lreg_d;
	logic ureg_q;
	logic ureg_d;
	logic [LRS_CNT_W-1:0] lcnt_q;
	logic [LRS_CNT_W-1:0] lcnt_d;
	logic [LRS_CNT_W-1:0] ucnt_q;
	logic [LRS_CNT_W-1:0] ucnt_d;
	logic bus_req;
	logic cfg_wr;
	logic lmode;
	logic umode;
	logic l_we;
	logic u_we;
	logic l_shift;
	logic u_shift;
	logic u_din;
	logic l_rd;
	logic u_rd;
	logic l_tail;
	logic u_tail;
	logic srst;
	logic [31:0] status;

	function automatic logic pick_d(input logic [1:0] sel, input logic bl, input logic bh,
		input logic wa, input logic wb);
		case (sel)
			LRS_D_BYP_LO: pick_d = bl;
			LRS_D_BYP_HI: pick_d = bh;
			LRS_D_WIDE_A: pick_d = wa;
			default: pick_d = wb;
		endcase
	endfunction : pick_d

	function automatic logic [LRS_CNT_W-1:0] bump(input logic [LRS_CNT_W-1:0] cnt,
		input logic clr, input logic step);
		if (clr) begin
			bump = '0;
		end else if (step && cnt != LRS_PRIMED_CNT) begin
			bump = LRS_CNT_W'(cnt + 1'b1);
		end else begin
			bump = cnt;
		end
	endfunction : bump

	// Reset released through two flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_sync_b <= rst_s1_q;
		end
	end

	assign lmode = cfg_q[LRS_CFG_LMODE];
	assign umode = cfg_q[LRS_CFG_UMODE];
	assign srst = cfg_q[LRS_CFG_SRST] && set_reset_in;
	// [RULE_09] set/reset doubles as RAM write enable
	assign l_we = (lmode == LRS_MODE_RAM) && set_reset_in;
	assign u_we = (umode == LRS_MODE_RAM) && set_reset_in;
	// [RULE_15] clock enable is the shift enable
	assign l_shift = (lmode == LRS_MODE_SHIFT) && clk_en;
	assign u_shift = (umode == LRS_MODE_SHIFT) && clk_en;
	// Linked chains form one 32-deep shift path
	assign u_din = cfg_q[LRS_CFG_LINK] ? l_tail : bypass_in_high;

	// [RULE_10] bypass inputs carry write data; the upper table takes the lower tail instead when linked
	lrs_lut_table u_lower (
		.clk(clk),
		.rst_sync_b(rst_sync_b),
		.mode(lmode),
		.write_en(l_we),
		.shift_en(l_shift),
		.write_data_in(bypass_in_low),
		.addr(lower_addr),
		.lut_out(l_rd),
		.chain_tail_out(l_tail)
	);

	lrs_lut_table u_upper (
		.clk(clk),
		.rst_sync_b(rst_sync_b),
		.mode(umode),
		.write_en(u_we),
		.shift_en(u_shift),
		.write_data_in(u_din),
		.addr(upper_addr),
		.lut_out(u_rd),
		.chain_tail_out(u_tail)
	);

	// Table reads must stay combinational, so these bypass the output flops
	// [RULE_07] written bit shows after the edge
	// [RULE_13] no clock needed for the read
	assign lower_lut_out = l_rd;
	assign upper_lut_out = u_rd;
	// [RULE_14] written data reaches the wide mux
	assign wide_mux_out = wide_mux_sel ? u_rd : l_rd;
	assign lower_mux_out = cfg_q[LRS_CFG_LOSEL] ? wide_mux_out : l_rd;
	assign upper_mux_out = cfg_q[LRS_CFG_UOSEL] ? wide_mux_out : u_rd;
	// [RULE_16] chain tails drive side and cascade outputs
	assign lower_side_out = l_tail;
	assign upper_side_out = u_tail;
	assign cascade_out = u_tail;

	// Slice flip-flops
	always_comb begin
		// [RULE_20] hold until cleared or enabled
		lreg_d = lreg_q;
		ureg_d = ureg_q;
		// [RULE_03] synchronous clear wins over load
		if (srst) begin
			lreg_d = 1'b0;
			ureg_d = 1'b0;
		// [RULE_01] load only when enabled
		end else if (clk_en) begin
			// [RULE_02] selectable data source
			lreg_d = pick_d(cfg_q[LRS_CFG_LSEL+:2], bypass_in_low, bypass_in_high,
				wide_mux_in_a, wide_mux_in_b);
			ureg_d = pick_d(cfg_q[LRS_CFG_USEL+:2], bypass_in_low, bypass_in_high,
				wide_mux_in_a, wide_mux_in_b);
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			lreg_q <= 1'b0;
			ureg_q <= 1'b0;
		end else begin
			lreg_q <= lreg_d;
			ureg_q <= ureg_d;
		end
	end

	// [RULE_04] registered results
	assign lower_reg_out = lreg_q;
	assign upper_reg_out = ureg_q;

	// Count enabled shifts; primed once the first bit sits at the tail
	always_comb begin
		// [RULE_19] sixteen shifts to reach the tail
		lcnt_d = bump(lcnt_q, cfg_wr || lmode != LRS_MODE_SHIFT, l_shift);
		ucnt_d = bump(ucnt_q, cfg_wr || umode != LRS_MODE_SHIFT, u_shift);
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			lcnt_q <= '0;
			ucnt_q <= '0;
		end else begin
			lcnt_q <= lcnt_d;
			ucnt_q <= ucnt_d;
		end
	end

	always_comb begin
		status = '0;
		status[LRS_ST_LREG] = lreg_q;
		status[LRS_ST_UREG] = ureg_q;
		status[LRS_ST_LLUT] = l_rd;
		status[LRS_ST_ULUT] = u_rd;
		status[LRS_ST_LTAIL] = l_tail;
		status[LRS_ST_UTAIL] = u_tail;
		status[LRS_ST_LPRIM] = (lcnt_q == LRS_PRIMED_CNT);
		status[LRS_ST_UPRIM] = (ucnt_q == LRS_PRIMED_CNT);
	end

	// Avalon slave: one wait cycle, then the answer
	assign bus_req = avs_read || avs_write;
	assign cfg_wr = avs_write && (bus_q == LRS_BUS_ANS) && (avs_address == LRS_CFG_OFS);

	always_comb begin
		bus_d = bus_q;
		wait_d = 1'b1;
		rdata_d = rdata_q;
		cfg_d = cfg_q;
		case (bus_q)
			LRS_BUS_IDLE: begin
				if (bus_req) begin
					bus_d = LRS_BUS_ANS;
					wait_d = 1'b0;
					rdata_d = '0;
					if (avs_read && avs_address == LRS_CFG_OFS) begin
						rdata_d[LRS_CFG_W-1:0] = cfg_q;
					end else if (avs_read && avs_address == LRS_STAT_OFS) begin
						rdata_d = status;
					end
				end
			end
			LRS_BUS_ANS: begin
				bus_d = LRS_BUS_IDLE;
				if (cfg_wr) begin
					if (avs_byteenable[0]) begin
						cfg_d[7:0] = avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						cfg_d[LRS_CFG_W-1:8] = avs_writedata[LRS_CFG_W-1:8];
					end
				end
			end
			default: begin
				bus_d = LRS_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			bus_q <= LRS_BUS_IDLE;
			wait_q <= 1'b1;
			rdata_q <= '0;
			cfg_q <= LRS_CFG_RST;
		end else begin
			bus_q <= bus_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			cfg_q <= cfg_d;
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	// [RULE_01] hold without enable
	a_ff_holds: assert property ( // RULE_01
		!clk_en && !srst |=> $stable(lower_reg_out) && $stable(upper_reg_out)
	) else $error("flip-flop changed without clock enable");
	// [RULE_02] capture from selected source
	a_ff_loads: assert property ( // RULE_02
		clk_en && !srst && cfg_q[LRS_CFG_LSEL+:2] == LRS_D_WIDE_A |=>
			lower_reg_out == $past(wide_mux_in_a)
	) else $error("lower flip-flop did not capture wide-mux input A");
	a_ff_loads_hi: assert property ( // RULE_04
		clk_en && !srst && cfg_q[LRS_CFG_USEL+:2] == LRS_D_BYP_HI |=>
			upper_reg_out == $past(bypass_in_high)
	) else $error("upper flip-flop did not capture upper bypass");
	// [RULE_03] synchronous clear
	a_ff_clears: assert property ( // RULE_03
		srst |=> !lower_reg_out && !upper_reg_out
	) else $error("synchronous reset did not clear flip-flops");
	// [RULE_20] zero held until a new load
	a_clear_held: assert property ( // RULE_20
		srst ##1 (!clk_en && !srst) [*2] |-> !lower_reg_out && !upper_reg_out
	) else $error("flip-flop left zero without an enabled load");
	// [RULE_07] written bit visible after the edge
	a_ram_readback: assert property ( // RULE_07
		l_we && $stable(lmode) ##1 $stable(lower_addr) |-> lower_lut_out == $past(bypass_in_low)
	) else $error("written RAM bit not on lower table output");
	// [RULE_14] write reaches the wide mux
	a_wide_sees_write: assert property ( // RULE_14
		u_we ##1 ($stable(upper_addr) && wide_mux_sel) |-> wide_mux_out == $past(u_din)
	) else $error("written RAM bit not on wide-mux output");
	// [RULE_17] serial input lands in position zero
	a_shift_pos0: assert property ( // RULE_17
		l_shift ##1 (lower_addr == 4'h0) |-> lower_lut_out == $past(bypass_in_low)
	) else $error("shifted bit not at position zero");
	// [RULE_19] first bit reaches the tail after sixteen shifts
	a_tail_primed: assert property ( // RULE_19
		lcnt_q == 5'h0F && l_shift && !cfg_wr |=> status[LRS_ST_LPRIM]
	) else $error("chain not primed after sixteen shifts");
	a_bus_answer: assert property (
		bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest
	) else $error("bus answer not exactly one cycle after the wait");
	// [RULE_07] upper write visible after the edge
	a_upper_readback: assert property ( // RULE_07
		u_we && !cfg_q[LRS_CFG_LINK] ##1 $stable(upper_addr) |->
			upper_lut_out == $past(bypass_in_high)
	) else $error("written RAM bit not on upper table output");
	// [RULE_02] capture from wide-mux input B
	a_ff_loads_b: assert property ( // RULE_02
		clk_en && !srst && cfg_q[LRS_CFG_USEL+:2] == LRS_D_WIDE_B |=>
			upper_reg_out == $past(wide_mux_in_b)
	) else $error("upper flip-flop did not capture wide-mux input B");
	// [RULE_13] address F reads the last location
	a_addr_f_tail: assert property ( // RULE_13
		lower_addr == 4'hF |-> lower_lut_out == lower_side_out
	) else $error("address F did not read the last location");
	// [RULE_19] any config write restarts the count
	a_prime_restart: assert property ( // RULE_19
		cfg_wr |=> !status[LRS_ST_LPRIM] && !status[LRS_ST_UPRIM]
	) else $error("chain still primed after a config write");
	a_cfg_lands: assert property (
		cfg_wr && avs_byteenable[0] |=> cfg_q[7:0] == $past(avs_writedata[7:0])
	) else $error("config write did not land");
	a_unmapped_zero: assert property (
		bus_q == LRS_BUS_IDLE && avs_read && avs_address != LRS_CFG_OFS &&
			avs_address != LRS_STAT_OFS |=> avs_readdata == 32'h0
	) else $error("unmapped read did not return zero");

	c_ff_clear_reload: cover property (srst ##1 clk_en && !srst);
	c_ram_write_read_f: cover property (l_we ##1 lower_addr == 4'hF);
	c_chain_primed: cover property (!status[LRS_ST_LPRIM] ##1 status[LRS_ST_LPRIM]);
	c_cfg_write: cover property (cfg_wr);
	c_linked_shift: cover property (u_shift && cfg_q[LRS_CFG_LINK]);
endmodule : lrs_slice
`default_nettype wire

/* lrs_user.sv */
// User logic model that drives the slice's fabric-side inputs
`timescale 1ns/1ps
`default_nettype none
module lrs_user
	import lrs_pkg::*;
(
	input wire logic clk,
	output var logic clk_en,
	output var logic set_reset_in,
	output var logic [3:0] ff_data,
	output var logic wide_mux_sel,
	output var logic [LRS_ADDR_W-1:0] lower_addr,
	output var logic [LRS_ADDR_W-1:0] upper_addr
);
	initial begin
		clk_en = 1'b0;
		set_reset_in = 1'b0;
		ff_data = 4'h0;
		wide_mux_sel = 1'b0;
		lower_addr = 4'h0;
		upper_addr = 4'h0;
	end
	// Order is wide_b, wide_a, bypass_high, bypass_low
	task automatic put_ff(input logic ce, input logic sr, input logic [3:0] d);
		@(posedge clk);
		clk_en <= ce;
		set_reset_in <= sr;
		ff_data <= d;
	endtask : put_ff
	task automatic ram_write(input logic [3:0] a, input logic dl, input logic dh);
		@(posedge clk);
		set_reset_in <= 1'b1;
		lower_addr <= a;
		upper_addr <= a;
		wide_mux_sel <= a[0];
		ff_data <= {2'h0, dh, dl};
		@(posedge clk);
		set_reset_in <= 1'b0;
	endtask : ram_write
	task automatic set_addr(input logic [3:0] la, input logic [3:0] ua, input logic sel);
		@(posedge clk);
		set_reset_in <= 1'b0;
		lower_addr <= la;
		upper_addr <= ua;
		wide_mux_sel <= sel;
	endtask : set_addr
	// Same serial bit feeds both chains
	task automatic shift_in(input logic b);
		@(posedge clk);
		clk_en <= 1'b1;
		ff_data <= {2'h0, b, b};
	endtask : shift_in
endmodule : lrs_user
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the LUT/RAM/shift slice
`timescale 1ns/1ps
`default_nettype none
module testbench
	import lrs_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, clk_en, set_reset_in, wide_mux_sel;
	logic [3:0] ff_data, lower_addr, upper_addr;
	logic lower_reg_out, upper_reg_out, lower_lut_out, upper_lut_out, wide_mux_out;
	logic lower_mux_out, upper_mux_out, lower_side_out, upper_side_out, cascade_out;
	int miscompares = 0;
	int n_tests = 0;
	always #25 clk = ~clk;
	lrs_slice i_lrs_slice (
		.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .clk_en, .set_reset_in,
		.bypass_in_low(ff_data[0]), .bypass_in_high(ff_data[1]),
		.wide_mux_in_a(ff_data[2]), .wide_mux_in_b(ff_data[3]), .wide_mux_sel,
		.lower_addr, .upper_addr, .lower_reg_out, .upper_reg_out, .lower_lut_out,
		.upper_lut_out, .lower_mux_out, .upper_mux_out, .wide_mux_out, .lower_side_out,
		.upper_side_out, .cascade_out
	);
	lrs_user i_lrs_user (
		.clk, .clk_en, .set_reset_in, .ff_data, .wide_mux_sel, .lower_addr, .upper_addr
	);
	task automatic stop_test;
		if (miscompares == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		@(posedge clk);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= wd;
		// A hang is ended by the watchdog
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic wcfg(input logic [9:0] v);
		bus(1'b1, LRS_CFG_OFS, {22'h0, v});
	endtask : wcfg
	task automatic settle;
		@(posedge clk);
		@(negedge clk);
	endtask : settle
	function automatic logic pat(input logic [3:0] a, input logic s);
		return ^a ^ s;
	endfunction : pat
	task automatic t_regs;
		bus(1'b0, LRS_CFG_OFS, 32'h0);
		chk(rd, {22'h0, LRS_CFG_RST});
		wcfg(10'h3FF);
		bus(1'b1, LRS_STAT_OFS, 32'hFFFFFFFF);
		bus(1'b0, LRS_CFG_OFS, 32'h0);
		chk(rd, 32'h3FF);
		bus(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h0);
	endtask : t_regs
	task automatic t_ff;
		for (int c = 0; c < 4; c++) begin
			wcfg({4'h0, c[1:0], c[1:0], 2'h0});
			i_lrs_user.put_ff(1'b1, 1'b0, 4'h1 << c);
			settle();
			chk({upper_reg_out, lower_reg_out}, 2'h3);
			i_lrs_user.put_ff(1'b1, 1'b0, ~(4'h1 << c));
			settle();
			chk({upper_reg_out, lower_reg_out}, 2'h0);
		end
		i_lrs_user.put_ff(1'b0, 1'b0, 4'hF);
		settle();
		chk({upper_reg_out, lower_reg_out}, 2'h0);
		wcfg(10'h040);
		i_lrs_user.put_ff(1'b1, 1'b0, 4'hF);
		settle();
		chk(lower_reg_out, 1'b1);
		// Clear must win over the enable
		i_lrs_user.put_ff(1'b1, 1'b1, 4'hF);
		settle();
		chk({upper_reg_out, lower_reg_out}, 2'h0);
		i_lrs_user.put_ff(1'b0, 1'b0, 4'hF);
		settle();
		chk(lower_reg_out, 1'b0);
		i_lrs_user.put_ff(1'b1, 1'b0, 4'hF);
		settle();
		chk(lower_reg_out, 1'b1);
	endtask : t_ff
	task automatic t_ram;
		logic lo, hi;
		wcfg(10'h000);
		for (int a = 0; a < 16; a++) begin
			i_lrs_user.ram_write(a[3:0], pat(a[3:0], 1'b0), pat(a[3:0], 1'b1));
			@(negedge clk);
			lo = pat(a[3:0], 1'b0);
			hi = pat(a[3:0], 1'b1);
			chk({wide_mux_out, lower_lut_out}, {a[0] ? hi : lo, lo});
		end
		// Upper reads the mirrored address to catch crossed decoders
		for (int a = 0; a < 16; a++) begin
			lo = pat(a[3:0], 1'b0);
			hi = pat(~a[3:0], 1'b1);
			i_lrs_user.set_addr(a[3:0], ~a[3:0], a[0]);
			@(negedge clk);
			chk({upper_mux_out, lower_mux_out, upper_lut_out, lower_lut_out}, {2{hi, lo}});
			chk(wide_mux_out, a[0] ? hi : lo);
		end
		i_lrs_user.set_addr(4'hE, 4'hE, 1'b0);
		i_lrs_user.set_addr(4'hF, 4'hF, 1'b0);
		@(negedge clk);
		chk(lower_lut_out, pat(4'hF, 1'b0));
		wcfg(10'h180);
		@(negedge clk);
		chk({upper_mux_out, lower_mux_out}, {2{pat(4'hF, 1'b0)}});
	endtask : t_ram
	task automatic t_shift;
		logic [31:0] s;
		s = 32'hA5C2_0000;
		i_lrs_user.put_ff(1'b0, 1'b0, 4'h0);
		wcfg(10'h003);
		i_lrs_user.set_addr(4'h0, 4'h0, 1'b0);
		bus(1'b0, LRS_STAT_OFS, 32'h0);
		chk(rd[7:6], 2'h0);
		for (int i = 0; i < 32; i++) begin
			i_lrs_user.shift_in(s[i]);
			@(negedge clk);
			if (i > 0) chk(lower_lut_out, s[i-1]);
			if (i >= 16) chk({cascade_out, upper_side_out, lower_side_out}, {3{s[i-16]}});
		end
		i_lrs_user.put_ff(1'b0, 1'b0, 4'h0);
		@(negedge clk);
		chk({cascade_out, lower_side_out}, {2{s[16]}});
		for (int j = 0; j < 16; j++) begin
			i_lrs_user.set_addr(j[3:0], j[3:0], 1'b1);
			@(negedge clk);
			chk({wide_mux_out, upper_lut_out, lower_lut_out}, {3{s[31-j]}});
		end
		i_lrs_user.put_ff(1'b0, 1'b0, 4'hF);
		settle();
		chk(lower_side_out, s[16]);
		bus(1'b0, LRS_STAT_OFS, 32'h0);
		chk(rd[7:6], 2'h3);
		// Linked: upper takes the lower tail instead of its bypass input
		wcfg(10'h203);
		i_lrs_user.set_addr(4'h0, 4'h0, 1'b0);
		i_lrs_user.shift_in(~s[16]);
		i_lrs_user.put_ff(1'b0, 1'b0, 4'h0);
		@(negedge clk);
		chk({upper_lut_out, lower_lut_out}, {s[16], ~s[16]});
	endtask : t_shift
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_ff();
		t_ram();
		t_shift();
		stop_test();
	end
	// Whole run needs well under 500 cycles
	initial begin
		#(50 * 2000);
		miscompares++;
		stop_test();
	end
endmodule : testbench
`default_nettype wire
